// *** hdl/dfm_monitor.sv ***
// drive fault monitor: sticky faults, class response, stop cause, led
`timescale 1ns/10ps
`default_nettype none
`include "dfm_params.svh"

// What this block does
// - A write of 8 to the drive control word requests a fault reset.
// - A class 0 fault only warns and movement goes on.
// - A class 1 fault quick-stops with power stage left enabled.
// - A class 2 fault quick-stops then disables power at standstill.
// - A class 3 fault disables power at once without decelerating.
// - A class 4 fault disables power at once and survives fault reset.
// - A bad firmware checksum flashes the led at 6 Hz as class 4.
// - Hardware faults flash at 10 Hz as class 4.
// - Fault bits stay set after the monitored condition goes away.
// - A fault reset clears the latched sticky fault bits unless class 4 is in force.
// - Bits 0, 1, 2 latch undervoltage 1, 2, overvoltage (class 2,3,3).
// - Bit 5 latches motor overload (class 1), bit 12 overtemperature (class 3).
// - Bit 16 latches a blocked drive as class 3.
// - Bit 21 latches a protocol error (class 1), bit 22 link loss as class 2.
// - Bit 25 both safe inputs low (class 3), bit 26 mismatch (class 4).
// - The error number of the latest interrupting fault not below the class in force is kept.
module dfm_monitor
    import dfm_pkg::*;
#(
    parameter int CLK_HZ = `DFM_CLK_HZ
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, power-on only
    input wire dfm_pkg::dfm_mon_t mon, // raw monitor levels
    input wire logic ctrl_wr, // drive control word write strobe
    input wire logic [15:0] ctrl_data, // drive control word value
    input wire logic standstill, // motor reached standstill
    output logic [31:0] sticky_fault_flags, // latched fault bits
    output logic [15:0] last_stop_cause, // last interrupting error number
    output dfm_pkg::dfm_class_t active_class, // class in force
    output dfm_pkg::dfm_resp_t resp, // response to motion/power stage
    output logic status_led // flashing status led
);
    import dfm_pkg::*;

    localparam logic [31:0] HALF_CHK = 32'(CLK_HZ / (2 * `DFM_BLINK_CHK_HZ));
    localparam logic [31:0] HALF_HW = 32'(CLK_HZ / (2 * `DFM_BLINK_HW_HZ));

    function automatic dfm_class_t max_class(input dfm_class_t a,
                                             input dfm_class_t b);
        max_class = (a > b) ? a : b;
    endfunction

    // =========================================================
    // input synchronisers
    // =========================================================
    dfm_mon_t mon_s;
    // safe inputs idle high: a zero reset value would fake a safe-low fault
    dfm_sync #(
        .WIDTH($bits(dfm_mon_t)),
        .RST_VAL(`DFM_MON_IDLE)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d(mon),
        .q(mon_s)
    );

    // =========================================================
    // event decode
    // =========================================================
    logic [31:0] ev;
    logic safe_low;
    logic safe_diff;
    logic fault_reset;
    always_comb begin
        ev = '0;
        safe_low = !mon_s.safe_a && !mon_s.safe_b;
        safe_diff = mon_s.safe_a != mon_s.safe_b;
        ev[`DFM_BIT_UV1] = mon_s.uv1;
        ev[`DFM_BIT_UV2] = mon_s.uv2;
        ev[`DFM_BIT_OV] = mon_s.ov;
        ev[`DFM_BIT_OVLD] = mon_s.overload;
        ev[`DFM_BIT_TEMP] = mon_s.overtemp;
        ev[`DFM_BIT_BLOCK] = mon_s.blocked;
        ev[`DFM_BIT_PROTO] = mon_s.proto_err;
        ev[`DFM_BIT_GUARD] = mon_s.guard_lost;
        ev[`DFM_BIT_SAFE_LOW] = safe_low;
        ev[`DFM_BIT_SAFE_DIFF] = safe_diff;
        ev[`DFM_BIT_HW] = mon_s.hw_fault;
        fault_reset = ctrl_wr && (ctrl_data == `DFM_CMD_FAULT_RESET);
    end

    // class and error number of each event, highest class wins
    dfm_class_t ev_class;
    logic [15:0] ev_num;
    logic ev_any;
    always_comb begin
        ev_class = DFM_CL_WARN;
        ev_num = 16'h0000;
        ev_any = 1'b0;
        for (int i = 0; i < 32; i++) begin
            dfm_class_t c;
            logic [15:0] n;
            c = DFM_CL_WARN;
            n = 16'h0000;
            unique case (i)
                `DFM_BIT_UV1: begin
                    c = DFM_CL_QSTOP_OFF;
                    n = `DFM_ERR_UV1;
                end
                `DFM_BIT_UV2: begin
                    c = DFM_CL_FATAL;
                    n = `DFM_ERR_UV2;
                end
                `DFM_BIT_OV: begin
                    c = DFM_CL_FATAL;
                    n = `DFM_ERR_OV;
                end
                `DFM_BIT_OVLD: begin
                    c = dfm_class_t'(`DFM_CLASS_OVLD);
                    n = `DFM_ERR_OVLD;
                end
                `DFM_BIT_TEMP: begin
                    c = DFM_CL_FATAL;
                    n = `DFM_ERR_TEMP;
                end
                `DFM_BIT_BLOCK: begin
                    c = DFM_CL_FATAL;
                    n = `DFM_ERR_BLOCK;
                end
                `DFM_BIT_PROTO: begin
                    c = dfm_class_t'(`DFM_CLASS_PROTO);
                    n = `DFM_ERR_PROTO;
                end
                `DFM_BIT_GUARD: begin
                    c = DFM_CL_QSTOP_OFF;
                    n = `DFM_ERR_GUARD;
                end
                `DFM_BIT_SAFE_LOW: begin
                    c = DFM_CL_FATAL;
                    n = `DFM_ERR_SAFE_LOW;
                end
                `DFM_BIT_SAFE_DIFF: begin
                    c = DFM_CL_UNCTRL;
                    n = `DFM_ERR_SAFE_DIFF;
                end
                `DFM_BIT_HW: begin
                    c = DFM_CL_UNCTRL;
                    n = `DFM_ERR_HW;
                end
                default: begin
                    c = DFM_CL_WARN;
                    n = 16'h0000;
                end
            endcase
            if (ev[i] && (!ev_any || c > ev_class)) begin
                ev_class = c;
                ev_num = n;
                ev_any = 1'b1;
            end
        end
    end

    // =========================================================
    // fault state
    // =========================================================
    logic [31:0] flags_r;
    logic [31:0] flags_nxt;
    dfm_class_t cls_r;
    dfm_class_t cls_nxt;
    logic [15:0] cause_r;
    logic [15:0] cause_nxt;
    logic chk_r;
    logic chk_nxt;
    logic hw_r;
    logic hw_nxt;
    logic off_r;
    logic off_nxt;
    always_comb begin
        flags_nxt = flags_r;
        cls_nxt = cls_r;
        cause_nxt = cause_r;
        chk_nxt = chk_r || mon_s.checksum_bad;
        hw_nxt = hw_r || mon_s.hw_fault;
        off_nxt = off_r;
        if (fault_reset && cls_r != DFM_CL_UNCTRL) begin
            flags_nxt = `DFM_FLAGS_RESET;
            cls_nxt = DFM_CL_WARN;
            off_nxt = 1'b0;
        end
        flags_nxt = flags_nxt | ev;
        if (cls_r == DFM_CL_UNCTRL) begin
            flags_nxt = flags_r | ev;
        end
        if (ev_any) begin
            cls_nxt = max_class(cls_nxt, ev_class);
            if (ev_class != DFM_CL_WARN && ev_class >= cls_nxt) begin
                cause_nxt = ev_num;
            end
        end
        if (mon_s.checksum_bad) begin
            cls_nxt = DFM_CL_UNCTRL;
        end
        if (cls_nxt == DFM_CL_QSTOP_OFF && standstill) begin
            off_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= `DFM_FLAGS_RESET;
            cls_r <= DFM_CL_WARN;
            cause_r <= 16'h0000;
            chk_r <= 1'b0;
            hw_r <= 1'b0;
            off_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            cls_r <= cls_nxt;
            cause_r <= cause_nxt;
            chk_r <= chk_nxt;
            hw_r <= hw_nxt;
            off_r <= off_nxt;
        end
    end

    // =========================================================
    // response outputs
    // =========================================================
    dfm_resp_t resp_r;
    dfm_resp_t resp_nxt;
    always_comb begin
        resp_nxt = '0;
        unique case (cls_r)
            DFM_CL_WARN: resp_nxt.warning = (flags_r != 32'h0);
            DFM_CL_QSTOP: resp_nxt.quick_stop = 1'b1;
            DFM_CL_QSTOP_OFF: begin
                resp_nxt.quick_stop = 1'b1;
                resp_nxt.power_off = off_r;
            end
            DFM_CL_FATAL: resp_nxt.power_off = 1'b1;
            DFM_CL_UNCTRL: begin
                resp_nxt.power_off = 1'b1;
                resp_nxt.locked = 1'b1;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_r <= '0;
        end else begin
            resp_r <= resp_nxt;
        end
    end

    // =========================================================
    // status led
    // =========================================================
    logic [31:0] half_sel;
    assign half_sel = hw_r ? HALF_HW : HALF_CHK;
    dfm_blink #(.CLK_HZ(CLK_HZ)) u_blink (
        .clk(clk),
        .rst(rst),
        .en(chk_r || hw_r),
        .half_period(half_sel),
        .led(status_led)
    );

    assign sticky_fault_flags = flags_r;
    assign last_stop_cause = cause_r;
    assign active_class = cls_r;
    assign resp = resp_r;
endmodule
`default_nettype wire

// *** common/dfm_params.svh ***
// constants of the drive fault monitor: bit positions, classes, codes, timing
`ifndef DFM_PARAMS_SVH
`define DFM_PARAMS_SVH

`define DFM_CLK_HZ 100000000
`define DFM_CMD_FAULT_RESET 16'h0008
`define DFM_BIT_UV1 0
`define DFM_BIT_UV2 1
`define DFM_BIT_OV 2
`define DFM_BIT_OVLD 5
`define DFM_BIT_TEMP 12
`define DFM_BIT_BLOCK 16
`define DFM_BIT_PROTO 21
`define DFM_BIT_GUARD 22
`define DFM_BIT_SAFE_LOW 25
`define DFM_BIT_SAFE_DIFF 26
`define DFM_BIT_HW 28
`define DFM_FLAGS_RESET 32'h0000_0000
`define DFM_MON_IDLE 12'h00c
`define DFM_CLASS_OVLD 3'h1
`define DFM_CLASS_PROTO 3'h1
`define DFM_ERR_UV1 16'h0100
`define DFM_ERR_UV2 16'h0101
`define DFM_ERR_OV 16'h0102
`define DFM_ERR_OVLD 16'h0105
`define DFM_ERR_TEMP 16'h010c
`define DFM_ERR_BLOCK 16'h0110
`define DFM_ERR_PROTO 16'h014d
`define DFM_ERR_GUARD 16'h014e
`define DFM_ERR_SAFE_LOW 16'h0119
`define DFM_ERR_SAFE_DIFF 16'h011a
`define DFM_ERR_HW 16'h0143
`define DFM_BLINK_CHK_HZ 6
`define DFM_BLINK_HW_HZ 10

`endif

// *** common/dfm_pkg.sv ***
// types of the drive fault monitor
`default_nettype none
package dfm_pkg;
    typedef enum logic [2:0] {
        DFM_CL_WARN, DFM_CL_QSTOP, DFM_CL_QSTOP_OFF, DFM_CL_FATAL,
        DFM_CL_UNCTRL
    } dfm_class_t;
    typedef struct packed {
        logic uv1;
        logic uv2;
        logic ov;
        logic overload;
        logic overtemp;
        logic blocked;
        logic proto_err;
        logic guard_lost;
        logic safe_a;
        logic safe_b;
        logic hw_fault;
        logic checksum_bad;
    } dfm_mon_t;
    typedef struct packed {
        logic quick_stop;
        logic power_off;
        logic warning;
        logic locked;
    } dfm_resp_t;
endpackage
`default_nettype wire

// *** hdl/dfm_sync.sv ***
// two-flop synchroniser for a bundle of monitor levels
`timescale 1ns/10ps
`default_nettype none
module dfm_sync #(
    parameter int WIDTH = 12,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [WIDTH-1:0] d, // asynchronous levels
    output logic [WIDTH-1:0] q // synchronised levels
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            // reset to the idle levels so no false event follows reset
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule
`default_nettype wire

// *** hdl/dfm_blink.sv ***
// status led flasher: toggles at twice the selected rate
`timescale 1ns/10ps
`default_nettype none
module dfm_blink #(
    parameter int CLK_HZ = 100000000
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic en, // flashing enabled
    input wire logic [31:0] half_period, // cycles per half period
    output logic led // led drive
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic led_r;
    logic led_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        led_nxt = led_r;
        if (!en) begin
            cnt_nxt = '0;
            led_nxt = 1'b0;
        end else if (cnt_r + 32'h1 >= half_period) begin
            cnt_nxt = '0;
            led_nxt = !led_r;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            led_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            led_r <= led_nxt;
        end
    end
    assign led = led_r;
endmodule
`default_nettype wire

// *** tb/dfm_master_model.sv ***
// fieldbus master model that writes the drive control word
`timescale 1ns/10ps
`default_nettype none
module dfm_master_model (
    input wire logic clk, // system clock
    input wire logic req, // send one write
    input wire logic [15:0] data, // value to send
    output logic ctrl_wr, // write strobe
    output logic [15:0] ctrl_data // control word
);
    initial begin
        ctrl_wr = 1'b0;
        ctrl_data = 16'h0000;
    end
    // ==========
    // one-cycle write, data scrambled while idle
    always @(posedge clk) begin
        ctrl_wr <= req;
        ctrl_data <= req ? data : ~ctrl_data;
    end
endmodule
`default_nettype wire

// *** tb/dfm_monitor_properties.sv ***
// port assertions of the drive fault monitor
`timescale 1ns/10ps
`default_nettype none
module dfm_monitor_properties
    import dfm_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    input wire dfm_pkg::dfm_mon_t mon, // monitor levels
    input wire logic ctrl_wr, // write strobe
    input wire logic [15:0] ctrl_data, // control word
    input wire logic standstill, // motor at rest
    input wire logic [31:0] sticky_fault_flags, // latched bits
    input wire logic [15:0] last_stop_cause, // stop cause
    input wire dfm_pkg::dfm_class_t active_class, // class in force
    input wire dfm_pkg::dfm_resp_t resp, // response
    input wire logic status_led // led
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rst_cmd;
    assign rst_cmd = ctrl_wr && ctrl_data == 16'h0008;
    // ==========
    // properties
    AST_UV1: assert property (
        mon.uv1 |-> ##[3:4] sticky_fault_flags[0])
        else $error("undervoltage 1 not latched");
    AST_UV2: assert property (
        mon.uv2 |-> ##[3:4] active_class >= DFM_CL_FATAL)
        else $error("undervoltage 2 class too low");
    AST_STICKY: assert property (
        !rst_cmd |=> (sticky_fault_flags & $past(sticky_fault_flags))
        == $past(sticky_fault_flags))
        else $error("fault bit dropped");
    AST_CLEAR: assert property (
        rst_cmd && active_class != DFM_CL_UNCTRL && mon == 12'h00c
        && $past(mon) == 12'h00c && $past(mon, 2) == 12'h00c
        && $past(mon, 3) == 12'h00c |=> sticky_fault_flags == 32'h0)
        else $error("fault reset did not clear");
    AST_LOCK: assert property (
        active_class == DFM_CL_UNCTRL |=> active_class == DFM_CL_UNCTRL)
        else $error("class 4 left");
    AST_SAFE_DIFF: assert property (
        mon.safe_a != mon.safe_b |-> ##[3:4] active_class == DFM_CL_UNCTRL)
        else $error("safe mismatch not class 4");
    AST_WARN: assert property (
        active_class == DFM_CL_WARN |=> !resp.quick_stop && !resp.power_off)
        else $error("warning interrupts motion");
    AST_QSTOP: assert property (
        active_class == DFM_CL_QSTOP |=> resp.quick_stop && !resp.power_off)
        else $error("class 1 response wrong");
    AST_QS_OFF: assert property (
        active_class == DFM_CL_QSTOP_OFF |=> resp.quick_stop)
        else $error("class 2 without quick stop");
    AST_STILL: assert property (
        active_class == DFM_CL_QSTOP_OFF && standstill && !rst_cmd
        |-> ##[1:3] resp.power_off)
        else $error("no power off at standstill");
    AST_FATAL: assert property (
        active_class >= DFM_CL_FATAL |=> resp.power_off && !resp.quick_stop)
        else $error("fatal class response wrong");
    cover property (rst_cmd && active_class == DFM_CL_UNCTRL);
    cover property (resp.power_off && active_class == DFM_CL_QSTOP_OFF);
    cover property ($rose(status_led));
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// testbench of the drive fault monitor
`timescale 1ns/10ps
`default_nettype none
`include "dfm_params.svh"
module tb;
    import dfm_pkg::*;
    localparam int HZ = 1200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    dfm_mon_t mon = 12'h00c;
    logic req = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic standstill = 1'b0;
    logic ctrl_wr;
    logic [15:0] ctrl_data;
    logic [31:0] flags;
    logic [15:0] cause;
    dfm_class_t cls;
    dfm_resp_t resp;
    logic led;
    int fails = 0;
    int compares = 0;
    always #5 clk = ~clk;
    dfm_master_model i_master (.clk(clk), .req(req), .data(wdata),
        .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data));
    dfm_monitor #(.CLK_HZ(HZ)) i_dut (.clk(clk), .rst(rst), .mon(mon),
        .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data), .standstill(standstill),
        .sticky_fault_flags(flags), .last_stop_cause(cause),
        .active_class(cls), .resp(resp), .status_led(led));
    // ==========
    // tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        mon <= 12'h00c;
        cyc(12);
        rst <= 1'b0;
        cyc(3);
    endtask
    task automatic send(input logic [15:0] v);
        req <= 1'b1;
        wdata <= v;
        cyc(1);
        req <= 1'b0;
        cyc(4);
    endtask
    task automatic fire(input logic [11:0] m);
        mon <= m;
        cyc(4);
        mon <= 12'h00c;
        cyc(6);
    endtask
    task automatic ev(input logic [11:0] m, input int b,
                      input logic [2:0] c, input logic [15:0] e);
        fire(m);
        chk(flags, 32'h1 << b);
        chk({29'h0, cls}, {29'h0, c});
        chk(cause, e);
        chk({resp.quick_stop, resp.power_off},
            c == 3'h3 ? 2'b01 : 2'b10);
        send(16'h0007);
        chk(flags, 32'h1 << b);
        send(16'h0008);
        chk(flags, 32'h0);
        chk({29'h0, cls}, 32'h0);
        chk({resp.quick_stop, resp.power_off}, 2'b00);
    endtask
    task automatic led_half(input int exp);
        int n;
        logic l0;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            l0 = led;
            while (led === l0 && n < 400) begin
                cyc(1);
                n++;
            end
        end
        chk(n, exp);
    endtask
    // ==========
    // tests
    initial begin
        do_reset;
        ev(12'h80c, `DFM_BIT_UV1, 3'h2, `DFM_ERR_UV1);
        ev(12'h40c, `DFM_BIT_UV2, 3'h3, `DFM_ERR_UV2);
        ev(12'h20c, `DFM_BIT_OV, 3'h3, `DFM_ERR_OV);
        ev(12'h10c, `DFM_BIT_OVLD, `DFM_CLASS_OVLD, `DFM_ERR_OVLD);
        ev(12'h08c, `DFM_BIT_TEMP, 3'h3, `DFM_ERR_TEMP);
        ev(12'h04c, `DFM_BIT_BLOCK, 3'h3, `DFM_ERR_BLOCK);
        ev(12'h02c, `DFM_BIT_PROTO, `DFM_CLASS_PROTO,
            `DFM_ERR_PROTO);
        ev(12'h01c, `DFM_BIT_GUARD, 3'h2, `DFM_ERR_GUARD);
        ev(12'h000, `DFM_BIT_SAFE_LOW, 3'h3, `DFM_ERR_SAFE_LOW);
        $display("test classes done");
        fire(12'h80c);
        standstill <= 1'b1;
        cyc(4);
        chk(resp.power_off, 1'b1);
        standstill <= 1'b0;
        send(16'h0008);
        fire(12'hc0c);
        chk({29'h0, cls}, 32'h3);
        chk(cause, `DFM_ERR_UV2);
        send(16'h0008);
        $display("test stop done");
        fire(12'h008);
        send(16'h0008);
        chk(flags, 32'h1 << `DFM_BIT_SAFE_DIFF);
        chk({29'h0, cls}, 32'h4);
        chk(resp.power_off, 1'b1);
        chk(resp.locked, 1'b1);
        chk(cause, `DFM_ERR_SAFE_DIFF);
        do_reset;
        chk(flags, 32'h0);
        mon <= 12'h00d;
        cyc(6);
        chk({29'h0, cls}, 32'h4);
        led_half(HZ / 12);
        do_reset;
        mon <= 12'h00e;
        cyc(6);
        chk(flags, 32'h1 << `DFM_BIT_HW);
        chk(cause, `DFM_ERR_HW);
        led_half(HZ / 20);
        $display("test fatal done");
        give_verdict;
    end
    initial begin
        cyc(20000);
        fails++;
        give_verdict;
    end
endmodule
bind dfm_monitor dfm_monitor_properties i_props (.clk(clk), .rst(rst),
    .mon(mon), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data),
    .standstill(standstill), .sticky_fault_flags(sticky_fault_flags),
    .last_stop_cause(last_stop_cause), .active_class(active_class),
    .resp(resp), .status_led(status_led));
`default_nettype wire
